// File: src/usfc_top.sv
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "usfc_cfg.svh"
module usfc_top (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // register bus
  input  wire logic [5:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  // serial pins
  output logic              transmit_pin_o,
  output logic              transmit_pin_oe,
  input  wire logic         receive_pin_i,
  output logic              receive_pin_owned,
  output logic              link_clock_pin_o,
  output logic              link_clock_pin_oe,
  // interrupt
  output logic              irq
);
  import usfc_pkg::*;

  // ********************************************************************
  // register state
  // ********************************************************************
  logic [7:0]     ctrl_b_reg;
  logic [7:0]     frame_reg;
  logic [11:0]    baud_reg;
  logic           dbl_reg;
  logic [2:0]     irq_stat_reg;
  logic [2:0]     irq_mask_reg;
  logic           gie_reg;
  logic           wait_reg;
  logic [31:0]    rd_next;
  logic           wr;
  logic           rd;
  logic [7:0]     wd;
  usfc_mode_t     mode;
  logic           serial_on;
  logic           rx_on;
  logic           te;

  // tx side
  logic [8:0]     tx_buf_reg;
  logic           tx_full_reg;
  logic           tx_own_reg;
  logic           tx_load;
  logic           tx_busy;
  logic           tx_done;
  logic           txd;

  // rx side
  logic           rx_meta_reg;
  logic           rx_s_reg;
  usfc_rx_state_t rx_st_reg;
  logic [3:0]     rx_ph_reg;
  logic [3:0]     rx_cnt_reg;
  logic [8:0]     rx_sh_reg;
  logic           rx_par_reg;
  logic [8:0]     rx_data_reg;
  logic           rx_full_reg;
  logic           fe_reg;
  logic           dor_reg;
  logic           upe_reg;
  logic           smp;
  logic           rx_done;
  logic [8:0]     rx_word;
  logic           rx_perr;
  logic [3:0]     os_top;
  logic [2:0]     ev;

  usfc_link_if link ();

  // ********************************************************************
  // decoded configuration
  // ********************************************************************
  assign mode      = usfc_mode_t'(frame_reg[`USFC_F_MODE]);
  // reserved and spi modes leave the serial engines idle
  assign serial_on = (mode == USFC_ASYNC) || (mode == USFC_SYNC);
  assign rx_on     = ctrl_b_reg[`USFC_B_RX_EN] && serial_on;
  assign te        = ctrl_b_reg[`USFC_B_TX_EN] && serial_on;
  assign os_top    = dbl_reg ? `USFC_OS_DOUBLE : `USFC_OS_NORMAL;

  assign link.div      = baud_reg;
  assign link.dbl      = dbl_reg && (mode == USFC_ASYNC);
  assign link.sync     = (mode == USFC_SYNC);
  assign link.pol      = frame_reg[`USFC_F_POL];
  assign link.nbits    = usfc_char_bits({ctrl_b_reg[`USFC_B_CSZ2], frame_reg[`USFC_F_CSZ]});
  assign link.par      = usfc_parity_t'(frame_reg[`USFC_F_PAR]);
  assign link.two_stop = frame_reg[`USFC_F_STOP];
  assign link.reload   = wr && (avs_address == `USFC_OFS_BAUD_LO);

  usfc_baud u_baud (
    .ref_clk (ref_clk),
    .rst     (rst),
    .lk      (link)
  );

  // ********************************************************************
  // bus slave: one wait state per access
  // ********************************************************************
  assign wr = avs_write && !wait_reg;
  assign rd = avs_read && !wait_reg;
  assign wd = avs_writedata[7:0];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= !((avs_read || avs_write) && wait_reg);
    end
  end

  always_comb begin
    rd_next = 32'h0000_0000;
    case (avs_address)
      `USFC_OFS_STATUS_A: begin
        rd_next[`USFC_B_RXC] = rx_full_reg;
        rd_next[`USFC_B_TXE] = !tx_full_reg;
        rd_next[`USFC_B_FE]  = fe_reg;
        rd_next[`USFC_B_DOR] = dor_reg;
        rd_next[`USFC_B_UPE] = upe_reg;
        rd_next[`USFC_B_DBL] = dbl_reg;
      end
      `USFC_OFS_CTRL_B:   rd_next[7:0] = {ctrl_b_reg[7:2], rx_data_reg[8], ctrl_b_reg[0]};
      `USFC_OFS_FRAME:    rd_next[7:0] = frame_reg;
      `USFC_OFS_BAUD_LO:  rd_next[7:0] = baud_reg[7:0];
      `USFC_OFS_BAUD_HI:  rd_next[3:0] = baud_reg[11:8];
      `USFC_OFS_DATA:     rd_next[7:0] = rx_data_reg[7:0];
      `USFC_OFS_IRQ_STAT: rd_next[2:0] = irq_stat_reg;
      `USFC_OFS_IRQ_MASK: rd_next[2:0] = irq_mask_reg;
      `USFC_OFS_GIE:      rd_next[0]   = gie_reg;
      default:            rd_next      = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && wait_reg) begin
      avs_readdata <= rd_next;
    end
  end

  assign avs_waitrequest = wait_reg;

  // ********************************************************************
  // control registers
  // ********************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_b_reg <= 8'h00;
      frame_reg  <= `USFC_RST_FRAME;
      dbl_reg    <= 1'b0;
      gie_reg    <= 1'b0;
      irq_mask_reg <= 3'h0;
    end else if (wr) begin
      case (avs_address)
        // completion enables live in the mask register instead
        `USFC_OFS_CTRL_B:   ctrl_b_reg <= {2'h0, wd[5:2], 1'b0, wd[0]};
        `USFC_OFS_FRAME:    frame_reg  <= wd;
        `USFC_OFS_STATUS_A: dbl_reg    <= wd[`USFC_B_DBL];
        `USFC_OFS_GIE:      gie_reg    <= wd[0];
        `USFC_OFS_IRQ_MASK: irq_mask_reg <= wd[2:0];
        default: ;
      endcase
    end
  end

  // reserved divisor bits are dropped, so a stray one cannot alter the rate
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      baud_reg <= `USFC_RST_BAUD;
    end else if (wr && avs_address == `USFC_OFS_BAUD_LO) begin
      baud_reg[7:0] <= wd;
    end else if (wr && avs_address == `USFC_OFS_BAUD_HI) begin
      baud_reg[11:8] <= wd[3:0];
    end
  end

  // ********************************************************************
  // transmit buffer and pin ownership
  // ********************************************************************
  assign tx_load = tx_full_reg && !tx_busy && tx_own_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_buf_reg  <= 9'h000;
      tx_full_reg <= 1'b0;
    end else if (wr && avs_address == `USFC_OFS_DATA && !tx_full_reg) begin
      // ninth bit is taken from the control register at this write
      tx_buf_reg  <= {ctrl_b_reg[`USFC_B_TX9], wd} &
                     ((9'h001 << link.nbits) - 9'h001);
      tx_full_reg <= 1'b1;
    end else if (tx_load) begin
      tx_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_own_reg <= 1'b0;
    end else begin
      tx_own_reg <= te || tx_busy || tx_load || (tx_full_reg && tx_own_reg);
    end
  end

  usfc_tx u_tx (
    .ref_clk (ref_clk),
    .rst     (rst),
    .load    (tx_load),
    .data    (tx_buf_reg),
    .txd     (txd),
    .busy    (tx_busy),
    .done    (tx_done),
    .lk      (link)
  );

  // ********************************************************************
  // receiver
  // ********************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_meta_reg <= 1'b1;
      rx_s_reg    <= 1'b1;
    end else begin
      rx_meta_reg <= receive_pin_i;
      rx_s_reg    <= rx_meta_reg;
    end
  end

  assign smp = link.sync ? link.rx_smp : (link.os_tick && rx_ph_reg == 4'h0);

  // sample phase: parks at half a bit while idle so the start bit is hit mid-bit
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_ph_reg <= 4'h0;
    end else if (link.os_tick) begin
      if (rx_st_reg == RX_IDLE) begin
        rx_ph_reg <= {1'b0, os_top[3:1]};
      end else if (rx_ph_reg == 4'h0) begin
        rx_ph_reg <= os_top;
      end else begin
        rx_ph_reg <= rx_ph_reg - 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || !rx_on) begin
      rx_st_reg  <= RX_IDLE;
      rx_cnt_reg <= 4'h0;
      rx_sh_reg  <= 9'h000;
      rx_par_reg <= 1'b0;
    end else begin
      unique case (rx_st_reg)
        RX_IDLE: begin
          if ((link.sync ? link.rx_smp : link.os_tick) && !rx_s_reg) begin
            rx_st_reg  <= link.sync ? RX_DATA : RX_START;
            rx_cnt_reg <= 4'h0;
          end
        end
        RX_START: begin
          if (smp) begin
            rx_st_reg <= rx_s_reg ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (smp) begin
            rx_sh_reg  <= {rx_s_reg, rx_sh_reg[8:1]};
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
            if (rx_cnt_reg == link.nbits - 4'h1) begin
              rx_st_reg <= link.par[1] ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (smp) begin
            rx_par_reg <= rx_s_reg;
            rx_st_reg  <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (smp) begin
            rx_st_reg <= RX_IDLE;
          end
        end
        default: rx_st_reg <= RX_IDLE;
      endcase
    end
  end

  assign rx_done = (rx_st_reg == RX_STOP) && smp;
  assign rx_word = rx_sh_reg >> (4'h9 - link.nbits);
  assign rx_perr = link.par[1] && (usfc_parity(rx_word, link.par) != rx_par_reg);

  // one-character receive buffer with its error flags
  always_ff @(posedge ref_clk) begin
    if (rst || !rx_on) begin
      rx_data_reg <= 9'h000;
      rx_full_reg <= 1'b0;
      fe_reg      <= 1'b0;
      dor_reg     <= 1'b0;
      upe_reg     <= 1'b0;
    end else if (rx_done && rx_full_reg) begin
      dor_reg <= 1'b1;
    end else if (rx_done) begin
      rx_data_reg <= rx_word;
      rx_full_reg <= 1'b1;
      fe_reg      <= !rx_s_reg;
      upe_reg     <= rx_perr;
      dor_reg     <= 1'b0;
    end else if (rd && avs_address == `USFC_OFS_DATA) begin
      rx_full_reg <= 1'b0;
      fe_reg      <= 1'b0;
      dor_reg     <= 1'b0;
      upe_reg     <= 1'b0;
    end
  end

  // ********************************************************************
  // interrupts
  // ********************************************************************
  assign ev[`USFC_I_RXC] = rx_done && !rx_full_reg;
  assign ev[`USFC_I_TXC] = tx_done && !tx_full_reg;
  assign ev[`USFC_I_ERR] = rx_done && (rx_full_reg || !rx_s_reg || rx_perr);

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_stat
      // a new event beats a write-one clear in the same cycle
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          irq_stat_reg[gi] <= 1'b0;
        end else if (ev[gi]) begin
          irq_stat_reg[gi] <= 1'b1;
        end else if (wr && avs_address == `USFC_OFS_IRQ_STAT && wd[gi]) begin
          irq_stat_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= gie_reg && ((ctrl_b_reg[`USFC_B_EMPTY_IE] && !tx_full_reg) ||
                         (|(irq_stat_reg & irq_mask_reg)));
    end
  end

  // ********************************************************************
  // pins
  // ********************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      transmit_pin_o    <= 1'b1;
      transmit_pin_oe   <= 1'b0;
      receive_pin_owned <= 1'b0;
      link_clock_pin_o  <= 1'b0;
      link_clock_pin_oe <= 1'b0;
    end else begin
      transmit_pin_o    <= txd;
      transmit_pin_oe   <= tx_own_reg;
      receive_pin_owned <= rx_on;
      link_clock_pin_o  <= link.xck;
      link_clock_pin_oe <= link.sync && (tx_own_reg || rx_on);
    end
  end

endmodule
`default_nettype wire

// File: src/usfc_cfg.svh
`ifndef USFC_CFG_SVH
`define USFC_CFG_SVH
// ********************************************************************
// register byte offsets
// ********************************************************************
`define USFC_OFS_STATUS_A  6'h00
`define USFC_OFS_CTRL_B    6'h04
`define USFC_OFS_FRAME     6'h08
`define USFC_OFS_BAUD_LO   6'h0c
`define USFC_OFS_BAUD_HI   6'h10
`define USFC_OFS_DATA      6'h14
`define USFC_OFS_IRQ_STAT  6'h18
`define USFC_OFS_IRQ_MASK  6'h1c
`define USFC_OFS_GIE       6'h20
// ********************************************************************
// field positions
// ********************************************************************
`define USFC_B_EMPTY_IE    5
`define USFC_B_RX_EN       4
`define USFC_B_TX_EN       3
`define USFC_B_CSZ2        2
`define USFC_B_RX9         1
`define USFC_B_TX9         0
`define USFC_B_RXC         7
`define USFC_B_TXE         5
`define USFC_B_FE          4
`define USFC_B_DOR         3
`define USFC_B_UPE         2
`define USFC_B_DBL         1
`define USFC_F_MODE        7:6
`define USFC_F_PAR         5:4
`define USFC_F_STOP        3
`define USFC_F_CSZ         2:1
`define USFC_F_POL         0
`define USFC_I_RXC         0
`define USFC_I_TXC         1
`define USFC_I_ERR         2
// ********************************************************************
// reset values and counts
// ********************************************************************
`define USFC_RST_FRAME     8'h06
`define USFC_RST_BAUD      12'h000
`define USFC_OS_NORMAL     4'hf
`define USFC_OS_DOUBLE     4'h7
`endif

// File: src/usfc_pkg.sv
`default_nettype none
package usfc_pkg;
  typedef enum logic [1:0] {
    USFC_ASYNC = 2'b00, USFC_SYNC = 2'b01, USFC_RSVD = 2'b10, USFC_MSPI = 2'b11
  } usfc_mode_t;
  typedef enum logic [1:0] {
    USFC_PAR_OFF = 2'b00, USFC_PAR_RSVD = 2'b01, USFC_PAR_EVEN = 2'b10, USFC_PAR_ODD = 2'b11
  } usfc_parity_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_WAIT = 3'b001, TX_START = 3'b010, TX_DATA = 3'b011,
    TX_PAR = 3'b100, TX_STOP1 = 3'b101, TX_STOP2 = 3'b110
  } usfc_tx_state_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010, RX_PAR = 3'b011,
    RX_STOP = 3'b100
  } usfc_rx_state_t;
  function automatic logic [3:0] usfc_char_bits(input logic [2:0] csz);
    case (csz)
      3'h0: usfc_char_bits = 4'h5;
      3'h1: usfc_char_bits = 4'h6;
      3'h2: usfc_char_bits = 4'h7;
      3'h7: usfc_char_bits = 4'h9;
      default: usfc_char_bits = 4'h8;
    endcase
  endfunction
  // data must arrive with unused upper bits at zero
  function automatic logic usfc_parity(input logic [8:0] d, input usfc_parity_t p);
    usfc_parity = (^d) ^ (p == USFC_PAR_ODD);
  endfunction
endpackage
`default_nettype wire

// File: src/usfc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface usfc_link_if;
  import usfc_pkg::*;
  logic         os_tick;
  logic         tx_tick;
  logic         rx_smp;
  logic         xck;
  logic [11:0]  div;
  logic         dbl;
  logic         sync;
  logic         pol;
  logic         reload;
  logic [3:0]   nbits;
  usfc_parity_t par;
  logic         two_stop;
  modport baud (input div, dbl, sync, pol, reload, output os_tick, tx_tick, rx_smp, xck);
  modport tx   (input tx_tick, nbits, par, two_stop);
  modport top  (output div, dbl, sync, pol, reload, nbits, par, two_stop,
                input os_tick, tx_tick, rx_smp, xck);
endinterface
`default_nettype wire

// File: src/usfc_baud.sv
`timescale 1ns/1ps
`default_nettype none
`include "usfc_cfg.svh"
module usfc_baud (
  // clock and reset
  input  wire logic  ref_clk,
  input  wire logic  rst,
  // link timing
  usfc_link_if.baud  lk
);
  import usfc_pkg::*;
  logic [11:0] pre_reg;
  logic [3:0]  os_reg;
  logic        xck_reg;
  logic        tick;
  logic [3:0]  os_top;
  assign tick   = (pre_reg == 12'h000);
  assign os_top = lk.dbl ? `USFC_OS_DOUBLE : `USFC_OS_NORMAL;
  // prescaler: one tick every div+1 clocks
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pre_reg <= `USFC_RST_BAUD;
    end else if (lk.reload || tick) begin
      pre_reg <= lk.div;
    end else begin
      pre_reg <= pre_reg - 12'h001;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst || lk.reload || lk.sync) begin
      os_reg <= 4'h0;
    end else if (tick) begin
      os_reg <= (os_reg >= os_top) ? 4'h0 : os_reg + 4'h1;
    end
  end
  // synchronous master clock toggles on each tick
  always_ff @(posedge ref_clk) begin
    if (rst || !lk.sync) begin
      xck_reg <= 1'b0;
    end else if (tick) begin
      xck_reg <= ~xck_reg;
    end
  end
  assign lk.os_tick = tick && !lk.sync;
  assign lk.tx_tick = lk.sync ? (tick && (xck_reg == lk.pol)) : (tick && os_reg >= os_top);
  assign lk.rx_smp  = lk.sync && tick && (xck_reg != lk.pol);
  assign lk.xck     = xck_reg;
endmodule
`default_nettype wire

// File: src/usfc_tx.sv
`timescale 1ns/1ps
`default_nettype none
module usfc_tx (
  // clock and reset
  input  wire logic  ref_clk,
  input  wire logic  rst,
  // character in
  input  wire logic  load,
  input  wire logic [8:0] data,
  // line side
  output logic       txd,
  output logic       busy,
  output logic       done,
  // timing and format
  usfc_link_if.tx    lk
);
  import usfc_pkg::*;
  usfc_tx_state_t st_reg;
  logic [8:0]     sh_reg;
  logic [3:0]     cnt_reg;
  logic           par_reg;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg  <= TX_IDLE;
      txd     <= 1'b1;
      sh_reg  <= 9'h000;
      cnt_reg <= 4'h0;
      par_reg <= 1'b0;
    end else if (st_reg == TX_IDLE) begin
      if (load) begin
        st_reg  <= TX_WAIT;
        sh_reg  <= data;
        par_reg <= usfc_parity(data, lk.par);
      end
    end else if (lk.tx_tick) begin
      unique case (st_reg)
        TX_WAIT: begin
          txd    <= 1'b0;
          st_reg <= TX_START;
        end
        TX_START, TX_DATA: begin
          txd     <= sh_reg[0];
          sh_reg  <= {1'b0, sh_reg[8:1]};
          cnt_reg <= (st_reg == TX_START) ? 4'h1 : cnt_reg + 4'h1;
          st_reg  <= TX_DATA;
          if (st_reg == TX_DATA && cnt_reg == lk.nbits) begin
            txd    <= (lk.par[1]) ? par_reg : 1'b1;
            st_reg <= lk.par[1] ? TX_PAR : TX_STOP1;
          end
        end
        TX_PAR: begin
          txd    <= 1'b1;
          st_reg <= TX_STOP1;
        end
        TX_STOP1: begin
          st_reg <= lk.two_stop ? TX_STOP2 : TX_IDLE;
        end
        TX_STOP2: begin
          st_reg <= TX_IDLE;
        end
        default: st_reg <= TX_IDLE;
      endcase
    end
  end
  assign busy = (st_reg != TX_IDLE);
  assign done = lk.tx_tick && ((st_reg == TX_STOP1 && !lk.two_stop) || st_reg == TX_STOP2);
endmodule
`default_nettype wire

// File: testbench/usfc_cfg_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "usfc_cfg.svh"
module usfc_cfg_checker (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // register bus
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // pins and interrupt
  input wire logic        transmit_pin_o,
  input wire logic        transmit_pin_oe,
  input wire logic        receive_pin_owned,
  input wire logic        link_clock_pin_oe,
  input wire logic        irq
);
  logic cb_wr;
  logic tx_on;
  logic own;
  assign cb_wr = avs_write && avs_address == `USFC_OFS_CTRL_B;
  assign tx_on = cb_wr && avs_writedata[3];
  assign own = transmit_pin_oe || receive_pin_owned;
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ack_once;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  AST_ONE_WAIT: assert property (s_req |=> s_ack_once)
    else $error("access not answered after one wait cycle");
  AST_NO_STRAY_ACK: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("acknowledge without request");
  AST_UNMAPPED: assert property (avs_read && avs_waitrequest && avs_address > 6'h20
    |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  // enable lands, then owner flop, then pin flop: the rise is seen three edges on
  AST_TX_OWN_ON: assert property ($rose(transmit_pin_oe) |-> $past(tx_on, 3))
    else $error("tx pin taken without enable write");
  AST_RX_OWN: assert property (!$stable(receive_pin_owned) |-> $past(cb_wr) || $past(cb_wr, 2))
    else $error("rx ownership moved without control write");
  AST_TX_START: assert property ($fell(transmit_pin_o) |-> transmit_pin_oe)
    else $error("start bit on unowned tx pin");
  AST_TX_RELEASE: assert property ($fell(transmit_pin_oe) |-> transmit_pin_o && $past(transmit_pin_o, 8))
    else $error("tx pin released mid frame");
  AST_LCK_OE: assert property (link_clock_pin_oe |-> own || $past(own))
    else $error("link clock driven while no engine owns pins");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("irq dropped without a register write");
endmodule
bind usfc_top usfc_cfg_checker u_chk (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
  .transmit_pin_o(transmit_pin_o), .transmit_pin_oe(transmit_pin_oe),
  .receive_pin_owned(receive_pin_owned), .link_clock_pin_oe(link_clock_pin_oe));
`default_nettype wire

// File: testbench/usfc_peer.sv
`timescale 1ns/1ps
`default_nettype none
module usfc_peer (
  // line side
  input  wire logic ref_clk,
  input  wire logic txd,
  output var logic  rxd
);
  // idle line rests at the pulled-up mark level
  initial rxd = 1'b1;
  // frame lsb first, start bit included; stop count is ours to pick
  task automatic send(input logic [11:0] b, input int n, input int bc);
    @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      rxd <= b[i];
      repeat (bc) @(posedge ref_clk);
    end
    rxd <= 1'b1;
  endtask
  // measures start length, then samples mid-bit; data bit 0 must be 1
  task automatic grab(input int n, input int bc, output logic [11:0] b, output int low);
    b = 12'h000;
    low = 0;
    @(posedge ref_clk iff !txd);
    while (!txd) begin
      low++;
      @(posedge ref_clk);
    end
    repeat (bc / 2) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      b[i] = txd;
      if (i < n - 1) repeat (bc) @(posedge ref_clk);
    end
  endtask
endmodule
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "usfc_cfg.svh"
module testbench;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [31:0] v;
  logic [11:0] got;
  logic        avs_waitrequest, tx_o, tx_oe, rx_i, rx_own, lck_o, lck_oe, irq;
  int          low, k;
  int          n_mismatch = 0;
  int          comparisons = 0;
  always #25 ref_clk = ~ref_clk;
  usfc_top u_dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .transmit_pin_o(tx_o), .transmit_pin_oe(tx_oe), .receive_pin_i(rx_i),
    .receive_pin_owned(rx_own), .link_clock_pin_o(lck_o), .link_clock_pin_oe(lck_oe));
  usfc_peer u_peer (.ref_clk(ref_clk), .txd(tx_o), .rxd(rx_i));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= 1'b1;
    @(posedge ref_clk iff !avs_waitrequest);
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge ref_clk iff !avs_waitrequest);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task automatic settle;
    // pin enables pass up to two flops after the write lands
    repeat (3) @(negedge ref_clk);
  endtask
  // pending frame must still leave after the enable is cleared
  task automatic tx(input logic [7:0] st, fr, cb, d, input int n, bc, input logic [11:0] eb);
    wr(`USFC_OFS_STATUS_A, st);
    wr(`USFC_OFS_FRAME, fr);
    wr(`USFC_OFS_CTRL_B, cb);
    settle();
    chk(tx_oe, 1);
    fork
      u_peer.grab(n, bc, got, low);
      begin
        wr(`USFC_OFS_DATA, d);
        wr(`USFC_OFS_CTRL_B, cb & 8'hf7);
      end
    join
    chk(low, bc);
    chk(got, eb);
    chk(tx_oe, 1);
    for (int i = 0; i < 99 && tx_oe; i++) @(negedge ref_clk);
    chk(tx_oe, 0);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge ref_clk);
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`USFC_OFS_FRAME, v);
    chk(v, 32'h06);
    rd(`USFC_OFS_STATUS_A, v);
    chk(v, 32'h20);
    rd(`USFC_OFS_CTRL_B, v);
    chk(v, 32'h00);
    rd(6'h3c, v);
    chk(v, 32'h00);
    wr(`USFC_OFS_CTRL_B, 8'h20);
    settle();
    chk(irq, 0);
    wr(`USFC_OFS_GIE, 8'h01);
    settle();
    chk(irq, 1);
    wr(`USFC_OFS_CTRL_B, 8'h00);
    settle();
    chk(irq, 0);
    wr(`USFC_OFS_BAUD_HI, 8'h00);
    wr(`USFC_OFS_BAUD_LO, 8'h01);
    tx(8'h00, 8'h2e, 8'h08, 8'ha5, 11, 32, 12'h6a5);
    tx(8'h02, 8'h00, 8'h08, 8'hf3, 6, 16, 12'h033);
    tx(8'h00, 8'h36, 8'h0d, 8'h01, 11, 32, 12'h701);
    wr(`USFC_OFS_FRAME, 8'h26);
    for (int p = 1; p >= 0; p--) begin
      wr(`USFC_OFS_CTRL_B, 8'h10);
      settle();
      chk(rx_own, 1);
      u_peer.send({1'b1, p[0], 8'h03, 1'b0}, 11, 32);
      rd(`USFC_OFS_STATUS_A, v);
      chk(v, 32'ha0 + 4 * p);
      if (p == 0) begin
        wr(`USFC_OFS_IRQ_MASK, 8'h01);
        settle();
        chk(irq, 1);
        wr(`USFC_OFS_IRQ_STAT, 8'h07);
        settle();
        chk(irq, 0);
        rd(`USFC_OFS_DATA, v);
        chk(v, 32'h03);
      end
      wr(`USFC_OFS_CTRL_B, 8'h00);
      rd(`USFC_OFS_STATUS_A, v);
      chk(v, 32'h20);
      chk(rx_own, 0);
    end
    wr(`USFC_OFS_FRAME, 8'h46);
    wr(`USFC_OFS_CTRL_B, 8'h08);
    settle();
    chk(lck_oe, 1);
    // clock toggles every div+1 clocks, so half of any 16 cycles are high
    k = 0;
    repeat (16) @(negedge ref_clk) k += lck_o;
    chk(k, 8);
    for (int m = 2; m < 4; m++) begin
      wr(`USFC_OFS_FRAME, {m[1:0], 6'h06});
      wr(`USFC_OFS_DATA, 8'h55);
      k = 0;
      repeat (64) @(negedge ref_clk) k += !tx_o;
      chk(k, 0);
    end
    finish_test();
  end
endmodule
`default_nettype wire
